/* pbf_defines.svh */
// register offsets, reset values and field layout for the pin function block
//
// How it works
// - pin 0 codes: port, first pwm, fast clock out, second comparator
// - pin 1 codes: port, second pwm, serial tx zero, serial tx one
// - pin 2 codes: port, third pwm; codes 10 and 11 prohibited
// - pin 3 codes: port, sync serial input, serial tx one; 11 prohibited
// - pin 4 codes: port, sync serial output, serial tx zero, tx one
// - pin 5 codes: port, sync serial clock, i2c clock, third fast pwm
// - pin 6 codes: port, external clock in, i2c data, second fast pwm
// - pin 7 codes: port, slow clock out, first fast pwm, first pwm
// - low select register at 0xF25C, byte/halfword access, resets to zero
// - prohibited code in output: data ignored; float on floating or p-channel, low on n-channel or push-pull
// - each pin is input or output by its own direction bit
// - output drive: floating, p-channel, n-channel open drain, push-pull
// - input condition: floating, pull-down or pull-up
// - after reset every pin is a floating output
// - output pins with port code 00 drive the stored data bit
// - in input mode a data read returns the sampled pin level
// - select code is high register bit n over low register bit n
// - drive code upper bit first: 00 float, 01 p/pd, 10 n/pu, 11 cmos
// - direction bit zero is output (reset), one is input
`ifndef PBF_DEFINES_SVH
`define PBF_DEFINES_SVH

`define PBF_ADDR_SEL_LOW   16'hF25C
`define PBF_ADDR_SEL_HIGH  16'hF260
`define PBF_ADDR_DATA      16'hF264
`define PBF_ADDR_DIR       16'hF268
`define PBF_ADDR_DRV_LOW   16'hF26C
`define PBF_ADDR_DRV_HIGH  16'hF270
`define PBF_RST_REG        8'h00
`define PBF_SEL_PORT       2'b00
`define PBF_SEL_ALT1       2'b01
`define PBF_SEL_ALT2       2'b10
`define PBF_SEL_ALT3       2'b11
`define PBF_DRV_FLOAT      2'b00
`define PBF_DRV_PCH        2'b01
`define PBF_DRV_NCH        2'b10
`define PBF_DRV_CMOS       2'b11
`define PBF_HTRANS_NONSEQ  2'b10

`endif

/* pbf_pkg.sv */
// types shared by the pin function block
package pbf_pkg;

  typedef struct packed {
    logic pwm_channel_first;
    logic pwm_channel_second;
    logic pwm_channel_third;
    logic fast_pwm_first;
    logic fast_pwm_second;
    logic fast_pwm_third;
    logic high_speed_clock_out;
    logic low_speed_clock_out;
    logic second_comparator_out;
    logic serial_tx_zero;
    logic serial_tx_one;
    logic sync_serial_out;
    logic sync_clock_out;
    logic sync_clock_oe;
    logic i2c_clock_out;
    logic i2c_data_out;
  } pbf_alt_out_t;

  typedef struct packed {
    logic sync_serial_in;
    logic sync_clock_in;
    logic external_clock_in;
    logic i2c_clock_in;
    logic i2c_data_in;
  } pbf_alt_in_t;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull_up;
    logic [7:0] pull_down;
  } pbf_pad_t;

endpackage

/* pbf_port.sv */
// pin function select, direction, drive type and data for an 8-bit port
`timescale 1ns/1ps
`default_nettype none
`include "pbf_defines.svh"

module pbf_port
  import pbf_pkg::*;
(
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         hsel,
  input  wire logic [31:0]  haddr,
  input  wire logic [1:0]   htrans,
  input  wire logic         hwrite,
  input  wire logic [2:0]   hsize,
  input  wire logic [31:0]  hwdata,
  input  wire logic         hready,
  output var  logic         hreadyout,
  output var  logic [31:0]  hrdata,
  output var  logic         hresp,
  input  wire logic [7:0]   pad_in,
  output var  pbf_pad_t     pad,
  input  wire pbf_alt_out_t alt_out,
  output var  pbf_alt_in_t  alt_in,
  output var  logic [7:0]   port_pin_level
);

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic [7:0]  sel_low_reg;
  logic [7:0]  sel_high_reg;
  logic [7:0]  data_reg;
  logic [7:0]  dir_reg;
  logic [7:0]  drv_low_reg;
  logic [7:0]  drv_high_reg;
  logic [7:0]  pin_level_reg;
  logic        wr_pend_reg;
  logic [15:0] wr_addr_reg;
  logic        rd_start;
  logic        wr_start;
  logic [7:0]  wbyte;
  logic [7:0]  rd_next;
  pbf_pad_t    pad_next;
  pbf_alt_in_t alt_in_next;
  logic [7:0]  mux_val;
  logic [7:0]  mux_en;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic hit(input logic [15:0] a, input logic [15:0] r);
    hit = (a[15:2] == r[15:2]);
  endfunction

  // true for the six register words only
  function automatic logic mapped(input logic [15:0] a);
    mapped = hit(a, `PBF_ADDR_SEL_LOW) || hit(a, `PBF_ADDR_SEL_HIGH) ||
             hit(a, `PBF_ADDR_DATA) || hit(a, `PBF_ADDR_DIR) ||
             hit(a, `PBF_ADDR_DRV_LOW) || hit(a, `PBF_ADDR_DRV_HIGH);
  endfunction

  function automatic logic pick(input logic [1:0] s, input logic v0,
                                input logic v1, input logic v2,
                                input logic v3);
    case (s)
      `PBF_SEL_PORT: pick = v0;
      `PBF_SEL_ALT1: pick = v1;
      `PBF_SEL_ALT2: pick = v2;
      default:       pick = v3;
    endcase
  endfunction

  // returns {oe, out} for one pin in output mode
  function automatic logic [1:0] drive(input logic out_mode,
                                       input logic [1:0] ctrl,
                                       input logic v);
    if (!out_mode) begin
      drive = 2'b00;
    end else begin
      case (ctrl)
        `PBF_DRV_PCH:  drive = v ? 2'b11 : 2'b00;
        `PBF_DRV_NCH:  drive = v ? 2'b00 : 2'b10;
        `PBF_DRV_CMOS: drive = {1'b1, v};
        default:       drive = 2'b00;
      endcase
    end
  endfunction

  // register read value, data register shows the pin in input mode
  function automatic logic [7:0] reg_read(input logic [15:0] a);
    if (hit(a, `PBF_ADDR_SEL_LOW)) begin
      reg_read = sel_low_reg;
    end else if (hit(a, `PBF_ADDR_SEL_HIGH)) begin
      reg_read = sel_high_reg;
    end else if (hit(a, `PBF_ADDR_DATA)) begin
      reg_read = (dir_reg & pin_level_reg) | (~dir_reg & data_reg);
    end else if (hit(a, `PBF_ADDR_DIR)) begin
      reg_read = dir_reg;
    end else if (hit(a, `PBF_ADDR_DRV_LOW)) begin
      reg_read = drv_low_reg;
    end else if (hit(a, `PBF_ADDR_DRV_HIGH)) begin
      reg_read = drv_high_reg;
    end else begin
      reg_read = 8'h00;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // bus slave

  assign rd_start = hsel && hready && (htrans == `PBF_HTRANS_NONSEQ) && !hwrite;
  assign wr_start = hsel && hready && (htrans == `PBF_HTRANS_NONSEQ) && hwrite;
  assign wbyte    = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 16'h0000;
    end else begin
      wr_pend_reg <= wr_start;
      if (wr_start) begin
        wr_addr_reg <= haddr[15:0];
      end
    end
  end

  // a read right behind a write to the same word, other than the data word, sees the new byte,
  // unmapped words keep reading zero
  always_comb begin
    rd_next = reg_read(haddr[15:0]);
    if (wr_pend_reg && mapped(wr_addr_reg) &&
        hit(haddr[15:0], wr_addr_reg) &&
        !hit(haddr[15:0], `PBF_ADDR_DATA)) begin
      rd_next = wbyte;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (rd_start) begin
        hrdata <= {24'h00_0000, rd_next};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file, byte lane 0 of each word

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_low_reg  <= `PBF_RST_REG;
      sel_high_reg <= `PBF_RST_REG;
      data_reg     <= `PBF_RST_REG;
      dir_reg      <= `PBF_RST_REG;
      drv_low_reg  <= `PBF_RST_REG;
      drv_high_reg <= `PBF_RST_REG;
    end else if (wr_pend_reg) begin
      if (hit(wr_addr_reg, `PBF_ADDR_SEL_LOW)) begin
        sel_low_reg <= wbyte;
      end
      if (hit(wr_addr_reg, `PBF_ADDR_SEL_HIGH)) begin
        sel_high_reg <= wbyte;
      end
      if (hit(wr_addr_reg, `PBF_ADDR_DATA)) begin
        data_reg <= wbyte;
      end
      if (hit(wr_addr_reg, `PBF_ADDR_DIR)) begin
        dir_reg <= wbyte;
      end
      if (hit(wr_addr_reg, `PBF_ADDR_DRV_LOW)) begin
        drv_low_reg <= wbyte;
      end
      if (hit(wr_addr_reg, `PBF_ADDR_DRV_HIGH)) begin
        drv_high_reg <= wbyte;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // function routing

  logic [1:0] s0, s1, s2, s3, s4, s5, s6, s7;

  assign s0 = {sel_high_reg[0], sel_low_reg[0]};
  assign s1 = {sel_high_reg[1], sel_low_reg[1]};
  assign s2 = {sel_high_reg[2], sel_low_reg[2]};
  assign s3 = {sel_high_reg[3], sel_low_reg[3]};
  assign s4 = {sel_high_reg[4], sel_low_reg[4]};
  assign s5 = {sel_high_reg[5], sel_low_reg[5]};
  assign s6 = {sel_high_reg[6], sel_low_reg[6]};
  assign s7 = {sel_high_reg[7], sel_low_reg[7]};

  always_comb begin
    mux_en     = 8'hFF;
    // prohibited codes carry a forced zero, data ignored
    mux_val[0] = pick(s0, data_reg[0], alt_out.pwm_channel_first,
                      alt_out.high_speed_clock_out,
                      alt_out.second_comparator_out);
    mux_val[1] = pick(s1, data_reg[1], alt_out.pwm_channel_second,
                      alt_out.serial_tx_zero,
                      alt_out.serial_tx_one);
    mux_val[2] = pick(s2, data_reg[2], alt_out.pwm_channel_third,
                      1'b0, 1'b0);
    mux_val[3] = pick(s3, data_reg[3], data_reg[3],
                      alt_out.serial_tx_one, 1'b0);
    mux_val[4] = pick(s4, data_reg[4], alt_out.sync_serial_out,
                      alt_out.serial_tx_zero,
                      alt_out.serial_tx_one);
    mux_val[5] = pick(s5, data_reg[5], alt_out.sync_clock_out,
                      1'b0, alt_out.fast_pwm_third);
    mux_val[6] = pick(s6, data_reg[6], data_reg[6],
                      1'b0, alt_out.fast_pwm_second);
    mux_val[7] = pick(s7, data_reg[7], alt_out.low_speed_clock_out,
                      alt_out.fast_pwm_first,
                      alt_out.pwm_channel_first);
    if (s5 == `PBF_SEL_ALT1) begin
      mux_en[5] = alt_out.sync_clock_oe;
    end else if (s5 == `PBF_SEL_ALT2) begin
      mux_en[5] = !alt_out.i2c_clock_out;
    end
    if (s6 == `PBF_SEL_ALT2) begin
      mux_en[6] = !alt_out.i2c_data_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pad drive

  always_comb begin
    logic [1:0] ctrl;
    logic [1:0] d;
    ctrl     = 2'b00;
    d        = 2'b00;
    pad_next = '0;
    for (int i = 0; i < 8; i++) begin
      ctrl = {drv_high_reg[i], drv_low_reg[i]};
      d    = drive(!dir_reg[i], ctrl, mux_val[i]);
      pad_next.oe[i]        = d[1] & mux_en[i];
      pad_next.out[i]       = d[0];
      pad_next.pull_down[i] = dir_reg[i] && (ctrl == `PBF_DRV_PCH);
      pad_next.pull_up[i]   = dir_reg[i] && (ctrl == `PBF_DRV_NCH);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pad <= '0;
    end else begin
      pad <= pad_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sampling and inputs to the peripherals

  always_comb begin
    alt_in_next                   = '0;
    alt_in_next.sync_serial_in    = (s3 == `PBF_SEL_ALT1) && pin_level_reg[3];
    alt_in_next.sync_clock_in     = (s5 == `PBF_SEL_ALT1) && pin_level_reg[5];
    alt_in_next.i2c_clock_in      = (s5 == `PBF_SEL_ALT2) && pin_level_reg[5];
    alt_in_next.external_clock_in = (s6 == `PBF_SEL_ALT1) && pin_level_reg[6];
    alt_in_next.i2c_data_in       = (s6 == `PBF_SEL_ALT2) && pin_level_reg[6];
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_level_reg  <= 8'h00;
      port_pin_level <= 8'h00;
      alt_in         <= '0;
    end else begin
      pin_level_reg  <= pad_in;
      port_pin_level <= pin_level_reg;
      alt_in         <= alt_in_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_pin0_comparator: assert property (
    (s0 == 2'b11 && !dir_reg[0] && drv_high_reg[0] && drv_low_reg[0])
    |=> (pad.oe[0] && pad.out[0] == $past(alt_out.second_comparator_out)))
    else $error("pin 0 does not carry the comparator output");

  a_pin1_txzero: assert property (
    (s1 == 2'b10 && !dir_reg[1] && drv_high_reg[1] && drv_low_reg[1])
    |=> (pad.oe[1] && pad.out[1] == $past(alt_out.serial_tx_zero)))
    else $error("pin 1 does not carry serial tx zero");

  a_prohib_float: assert property (
    (s2[1] && !dir_reg[2] && !drv_high_reg[2]) |=> !pad.oe[2])
    else $error("prohibited pin 2 drives while floating type chosen");

  a_prohib_nch_low: assert property (
    (s3 == 2'b11 && !dir_reg[3] && drv_high_reg[3] && !drv_low_reg[3]
     && data_reg[3]) |=> (pad.oe[3] && !pad.out[3]))
    else $error("prohibited pin 3 not held low in n-channel mode");

  a_prohib_cmos_low: assert property (
    (s2 == 2'b10 && !dir_reg[2] && drv_high_reg[2] && drv_low_reg[2])
    |=> (pad.oe[2] && !pad.out[2]))
    else $error("prohibited pin 2 not held low in push-pull mode");

  a_input_nodrive: assert property (
    ##1 ((pad.oe & $past(dir_reg)) == 8'h00))
    else $error("an input pin is driven");

  a_gpio_drive: assert property (
    (s4 == 2'b00 && !dir_reg[4] && drv_high_reg[4] && drv_low_reg[4])
    [*2] |-> (pad.oe[4] && pad.out[4] == $past(data_reg[4])))
    else $error("port pin 4 does not show the data bit");

  a_pull_up: assert property (
    (dir_reg[7] && drv_high_reg[7] && !drv_low_reg[7])
    |=> (pad.pull_up[7] && !pad.pull_down[7] && !pad.oe[7]))
    else $error("pin 7 pull-up missing in input mode");

  a_sel_write: assert property (
    (wr_start && hit(haddr[15:0], `PBF_ADDR_SEL_LOW)) ##1 1'b1
    |=> (sel_low_reg == $past(hwdata[7:0])))
    else $error("select low write not stored");

  a_data_read: assert property (
    (rd_start && hit(haddr[15:0], `PBF_ADDR_DATA))
    |=> (hrdata[7:0] == (($past(dir_reg) & $past(pin_level_reg)) |
                         (~$past(dir_reg) & $past(data_reg)))))
    else $error("data read does not mix pin level and data");

  a_float_type: assert property (
    ((drv_high_reg | drv_low_reg) == 8'h00) |=> (pad.oe == 8'h00))
    else $error("floating type drives a pin");

  a_pin7_pwm: assert property (
    (s7 == 2'b11 && !dir_reg[7] && drv_high_reg[7] && drv_low_reg[7])
    |=> (pad.oe[7] && pad.out[7] == $past(alt_out.pwm_channel_first)))
    else $error("pin 7 does not carry the first pwm output");

  a_pin5_i2c_low: assert property (
    (s5 == 2'b10 && !dir_reg[5] && drv_high_reg[5] && !drv_low_reg[5]
     && !alt_out.i2c_clock_out) |=> (pad.oe[5] && !pad.out[5]))
    else $error("pin 5 i2c clock not pulled low");

  a_pull_down: assert property (
    (dir_reg[0] && !drv_high_reg[0] && drv_low_reg[0])
    |=> (pad.pull_down[0] && !pad.pull_up[0] && !pad.oe[0]))
    else $error("pin 0 pull-down missing in input mode");

  a_alt_in_gate: assert property (
    (s6 != 2'b10) |=> !alt_in.i2c_data_in)
    else $error("i2c data input passed while not selected");

  a_read_bypass: assert property (
    (wr_start && hit(haddr[15:0], `PBF_ADDR_SEL_LOW))
    ##1 (rd_start && hit(haddr[15:0], `PBF_ADDR_SEL_LOW))
    |=> (hrdata[7:0] == $past(hwdata[7:0])))
    else $error("read right after write misses the new byte");

  a_unmapped_read: assert property (
    (rd_start && !mapped(haddr[15:0])) |=> (hrdata == 32'h0000_0000))
    else $error("unmapped word reads nonzero");

  c_prohib_used: cover property (s2 == 2'b11 && !dir_reg[2]);
  c_read_after_write: cover property (wr_pend_reg && rd_start);
  c_pin0_comparator: cover property (s0 == 2'b11 && !dir_reg[0]);
  c_i2c_low: cover property (s5 == 2'b10 && pad.oe[5]);
  c_input_read: cover property (rd_start && dir_reg != 8'h00);

endmodule
`default_nettype wire

/* tb_port_b_function_select_io.sv */
// self-checking bench for the port b pin function block
`timescale 1ns/1ps
`default_nettype none
`include "pbf_defines.svh"

module tb_port_b_function_select_io
  import pbf_pkg::*;
;
  logic         hclk;
  logic         hresetn;
  logic         hsel;
  logic         hwrite;
  logic         hreadyout;
  logic         hresp;
  logic [1:0]   htrans;
  logic [2:0]   hsize;
  logic [31:0]  haddr;
  logic [31:0]  hwdata;
  logic [31:0]  hrdata;
  logic [7:0]   pad_in;
  logic [7:0]   port_pin_level;
  pbf_pad_t     pad;
  pbf_alt_out_t alt_out;
  pbf_alt_in_t  alt_in;
  logic [7:0]   r [6];
  logic [31:0]  seed;
  logic [31:0]  rd;
  int           n_mismatch;
  int           checks_done;
  int           cyc;
  wire logic    hready;

  assign hready = hreadyout;

  pbf_port uut (
    .hclk           (hclk),
    .hresetn        (hresetn),
    .hsel           (hsel),
    .haddr          (haddr),
    .htrans         (htrans),
    .hwrite         (hwrite),
    .hsize          (hsize),
    .hwdata         (hwdata),
    .hready         (hready),
    .hreadyout      (hreadyout),
    .hrdata         (hrdata),
    .hresp          (hresp),
    .pad_in         (pad_in),
    .pad            (pad),
    .alt_out        (alt_out),
    .alt_in         (alt_in),
    .port_pin_level (port_pin_level)
  );

  always #5 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] addr_of(input int i);
    return 32'(`PBF_ADDR_SEL_LOW) + 32'(4 * i);
  endfunction

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // one single ahb-lite transfer, waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a,
                     input logic [7:0] d, output logic [31:0] q);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    hsize  <= 3'b010;
    htrans <= `PBF_HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wr ? {24'h00_0000, d} : 32'h0000_0000;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // expected pin behaviour, returns {out, oe, pull_up, pull_down}
  function automatic logic [3:0] exp_pin(input int n, input pbf_alt_out_t a);
    logic [1:0] code;
    logic [1:0] dv;
    logic [3:0] t;
    logic       v;
    logic       oe;
    logic       g;
    code = {r[1][n], r[0][n]};
    dv = {r[5][n], r[4][n]};
    v = r[2][n];
    case (n)
      0: t = {a.second_comparator_out, a.high_speed_clock_out,
              a.pwm_channel_first, v};
      1: t = {a.serial_tx_one, a.serial_tx_zero,
              a.pwm_channel_second, v};
      2: t = {1'b0, 1'b0, a.pwm_channel_third, v};
      3: t = {1'b0, a.serial_tx_one, v, v};
      4: t = {a.serial_tx_one, a.serial_tx_zero, a.sync_serial_out,
              v};
      5: t = {a.fast_pwm_third, a.i2c_clock_out, a.sync_clock_out,
              v};
      6: t = {a.fast_pwm_second, a.i2c_data_out, v, v};
      default: t = {a.pwm_channel_first, a.fast_pwm_first,
                    a.low_speed_clock_out, v};
    endcase
    v = t[code];
    g = 1'b1;
    if (n == 5 && code == 2'b01) g = a.sync_clock_oe;
    if ((n == 5 || n == 6) && code == 2'b10) g = ~v;
    oe = (dv == 2'b11) | (dv == 2'b01 & v) | (dv == 2'b10 & ~v);
    oe = oe & g & ~r[3][n];
    return {v & oe, oe, r[3][n] & dv == 2'b10, r[3][n] & dv == 2'b01};
  endfunction

  function automatic pbf_alt_in_t exp_in(input logic [7:0] l);
    pbf_alt_in_t e;
    e.sync_serial_in = {r[1][3], r[0][3]} == 2'b01 & l[3];
    e.sync_clock_in = {r[1][5], r[0][5]} == 2'b01 & l[5];
    e.external_clock_in = {r[1][6], r[0][6]} == 2'b01 & l[6];
    e.i2c_clock_in = {r[1][5], r[0][5]} == 2'b10 & l[5];
    e.i2c_data_in = {r[1][6], r[0][6]} == 2'b10 & l[6];
    return e;
  endfunction

  task automatic check_pins;
    logic [3:0] p;
    logic [7:0] eo;
    logic [7:0] eoe;
    logic [7:0] epu;
    logic [7:0] epd;
    for (int n = 0; n < 8; n++) begin
      p = exp_pin(n, alt_out);
      {eo[n], eoe[n], epu[n], epd[n]} = p;
    end
    chk("pad oe", 32'(pad.oe), 32'(eoe));
    chk("pad out", 32'(pad.out & pad.oe), 32'(eo));
    chk("pad pull up", 32'(pad.pull_up), 32'(epu));
    chk("pad pull down", 32'(pad.pull_down), 32'(epd));
    chk("alt in", 32'(alt_in), 32'(exp_in(pad_in)));
    chk("pin level", 32'(port_pin_level), 32'(pad_in));
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // timeout
  always @(posedge hclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      close_out;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'b00;
    hsize = 3'b010;
    haddr = 32'h0000_0000;
    hwdata = 32'h0000_0000;
    pad_in = 8'h00;
    alt_out = '0;
    seed = 32'haf29_0846;
    n_mismatch = 0;
    checks_done = 0;
    cyc = 0;
    foreach (r[i]) r[i] = 8'h00;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    chk("pad after reset", pad, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, addr_of(i), 8'h00, rd);
      chk("register reset", rd, 32'h0000_0000);
    end
    bus(1'b1, addr_of(0), 8'h5a, rd);
    bus(1'b0, addr_of(0), 8'h00, rd);
    chk("read after write", rd, 32'h0000_005a);
    bus(1'b1, addr_of(6), 8'hff, rd);
    bus(1'b0, addr_of(6), 8'h00, rd);
    chk("unmapped read", rd, 32'h0000_0000);
    for (int k = 0; k < 64; k++) begin
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        r[i] = seed[7:0];
      end
      if (k < 16) begin
        r[0] = {8{k[0]}};
        r[1] = {8{k[1]}};
        r[4] = {8{k[2]}};
        r[5] = {8{k[3]}};
        if (k == 1) r[3] = 8'h00;
        if (k == 2) r[3] = 8'hff;
      end
      seed = lfsr(seed);
      alt_out <= seed[15:0];
      pad_in <= seed[23:16];
      for (int i = 0; i < 6; i++) bus(1'b1, addr_of(i), r[i], rd);
      repeat (3) @(posedge hclk);
      check_pins;
      for (int i = 0; i < 6; i++) begin
        bus(1'b0, addr_of(i), 8'h00, rd);
        if (i == 2) begin
          chk("data read", rd, {24'h00_0000,
              (r[3] & pad_in) | (~r[3] & r[2])});
        end else begin
          chk("register read", rd, {24'h00_0000, r[i]});
        end
      end
      chk("hresp", 32'(hresp), 32'h0000_0000);
      chk("hreadyout", 32'(hreadyout), 32'h0000_0001);
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("pad in reset", pad, 32'h0000_0000);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, addr_of(0), 8'h00, rd);
    chk("select low after reset", rd, 32'h0000_0000);
    bus(1'b0, addr_of(1), 8'h00, rd);
    chk("select high after reset", rd, 32'h0000_0000);
    close_out;
  end
endmodule
`default_nettype wire
